//--- rtl/spi_audio_serial_port.sv
// serial port with audio codec options, APB registers and small buffers
// Contract
// - master: sample-phase bit picks end or middle of output bit time
// - slave mode ignores sample-phase and behaves as if it were zero
// - edge select one: data changes active-to-idle; zero: idle-to-active
// - slave-select enable makes the active-low select pin used in slave
// - polarity one: clock idles high; zero: clock idles low
// - audio enabled forces idle-high clock regardless of stored polarity
// - master-mode select one means master, zero means slave
// - input-disable one leaves data input pin unused by the port
// - transmit irq: not full, half empty, empty, or shifting done
// - receive irq: full, half full, not empty, or read empties it
// - sign-extend bit extends received data to register width
// - separate enables gate frame error, overflow, underrun error events
// - ignore-overflow keeps buffer data; otherwise overflow stops port
// - ignore-underrun sends zeros; otherwise underrun stops port
// - audio-enable switches to audio codec operation
// - mono sends each word on left and right channel
// - protocol field selects PCM, right, left justified or I2S; the code only reports it in status, bit timing ignores it
// - audio, mono and protocol bits writable only while port off
// - mono and protocol only take effect while audio enabled
// - on bit enables the port when set, disables it when clear
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module spi_audio_serial_port #(
  parameter int W        = spi_audio_pkg::DATA_W_DEF,
  parameter int DEPTH    = spi_audio_pkg::FIFO_DEPTH_DEF,
  parameter int HALF_DIV = spi_audio_pkg::HALF_DIV_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk_in,
  input  wire logic        sdi_in,
  input  wire logic        ss_n_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             sdo_out,
  output logic             sdo_oe,
  output logic             sdi_used,
  output logic             ss_used,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             error_event
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam int HB = $clog2(2 * W + 1);
  localparam int DB = $clog2(HALF_DIV);
  localparam logic [HB-1:0] LAST_M   = HB'(2 * W);
  localparam logic [HB-1:0] LAST_S   = HB'(2 * W - 1);
  localparam logic [CW-1:0] FULL     = CW'(DEPTH);
  localparam logic [CW-1:0] TX_HALF  = CW'(DEPTH - DEPTH / 2);
  localparam logic [CW-1:0] RX_HALF  = CW'((DEPTH + 1) / 2);
  localparam logic [CW-1:0] ONE      = CW'(1);
  localparam logic [DB-1:0] DIV_LAST = DB'(HALF_DIV - 1);

  // circular pointer advance shared by both buffers
  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  logic [31:0]   ctrl_q;
  logic [31:0]   ctrl2_q;
  logic          sclk_m_q, sclk_s_q, sclk_prev_q;
  logic          sdi_m_q, sdi_s_q, ss_m_q, ss_s_q;
  spi_audio_pkg::eng_state_t state_q;
  logic [HB-1:0] half_q;
  logic [DB-1:0] div_q;
  logic [W-1:0]  tx_sh_q, rx_sh_q, last_word_q;
  logic          loaded_q, chan_q;
  logic [W-1:0]  tx_mem [DEPTH];
  logic [W-1:0]  rx_mem [DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [CW-1:0] tx_cnt_q, rx_cnt_q;
  logic          ovf_q, urf_q, fef_q;

  logic          on, master, audio, cke, cpol_eff, smp_eff, mono_eff, sel;
  logic [1:0]    prot_eff;
  logic          tick, last, cap, shf, sdi_bit, repeat_word, load_now;
  logic          start_m, starved, over, crit, rx_push, rx_full, frame_err;
  logic [W-1:0]  rx_word;
  logic          acc, done, hit, wr_ctrl, wr_ctrl2, wr_stat, tx_push;
  logic          tx_pop, rx_pop, off_now;
  logic [31:0]   rd_data, ctrl_wval, ctrl2_wval, status;

  // effective settings
  assign on       = ctrl_q[spi_audio_pkg::ON_BIT];
  assign master   = ctrl_q[spi_audio_pkg::MASTER_MODE_SELECT_BIT];
  assign audio    = ctrl2_q[spi_audio_pkg::AUDIO_ENABLE_BIT];
  assign cke      = ctrl_q[spi_audio_pkg::CKE_BIT];
  assign cpol_eff = audio | ctrl_q[spi_audio_pkg::CKP_BIT];
  assign smp_eff  = master & ctrl_q[spi_audio_pkg::SMP_BIT];
  assign mono_eff = audio & ctrl2_q[spi_audio_pkg::MONO_BIT];
  assign prot_eff = audio ? ctrl2_q[spi_audio_pkg::AUDIO_PROTOCOL_SELECT_LSB +: 2]
                          : spi_audio_pkg::PROTO_I2S;
  assign sel      = ~ctrl_q[spi_audio_pkg::SLAVE_SELECT_ENABLE_BIT] | ~ss_s_q;
  assign sdi_bit  = ~ctrl_q[spi_audio_pkg::SERIAL_INPUT_DISABLE_BIT] & sdi_s_q;

  // bit timing: half periods in master, synchronised pin edges in slave
  assign tick = (state_q == spi_audio_pkg::ST_RUN) &&
                (master ? (div_q == DIV_LAST) : (sclk_s_q != sclk_prev_q));
  assign last = tick && (half_q == (master ? LAST_M : LAST_S));
  // late sampling moves capture one half period, to the end of the bit
  assign cap  = tick && (half_q[0] == (~cke ^ smp_eff)) &&
                (smp_eff ? (half_q != '0) : (half_q != LAST_M));
  assign shf  = tick && (half_q[0] == cke) &&
                (cke || (half_q != '0));
  assign rx_word = cap ? {rx_sh_q[W-2:0], sdi_bit} : rx_sh_q;

  // word loading, underrun and overflow detection
  assign repeat_word = mono_eff & chan_q;
  assign load_now = on && !loaded_q && ((tx_cnt_q != '0) || repeat_word) &&
                    ((state_q == spi_audio_pkg::ST_IDLE) ||
                     ((state_q == spi_audio_pkg::ST_RUN) &&
                      (half_q == '0) && !tick));
  assign tx_pop  = load_now && !repeat_word;
  assign start_m = on && master && (state_q == spi_audio_pkg::ST_IDLE) &&
                   (loaded_q || (audio && !load_now));
  assign starved = !loaded_q &&
                   (master ? start_m
                           : (tick && (half_q == '0)));
  assign rx_full = (rx_cnt_q == FULL);
  assign over    = last && rx_full;
  assign rx_push = last && !rx_full;
  assign crit    = (over && !ctrl2_q[spi_audio_pkg::IGNOV_BIT]) ||
                   (starved && !ctrl2_q[spi_audio_pkg::IGNUR_BIT]);
  assign frame_err = on && !master && ctrl_q[spi_audio_pkg::SLAVE_SELECT_ENABLE_BIT] &&
                     (state_q == spi_audio_pkg::ST_RUN) && ss_s_q &&
                     (half_q != '0);

  // APB decode: one wait state, effects at the completing edge
  assign acc      = psel & penable;
  assign done     = acc & pready;
  assign hit      = (paddr == spi_audio_pkg::CTRL_OFS) ||
                    (paddr == spi_audio_pkg::CTRL2_OFS) ||
                    (paddr == spi_audio_pkg::TXDATA_OFS) ||
                    (paddr == spi_audio_pkg::RXDATA_OFS) ||
                    (paddr == spi_audio_pkg::STATUS_OFS);
  assign wr_ctrl  = done & pwrite & (paddr == spi_audio_pkg::CTRL_OFS);
  assign wr_ctrl2 = done & pwrite & (paddr == spi_audio_pkg::CTRL2_OFS);
  assign wr_stat  = done & pwrite & (paddr == spi_audio_pkg::STATUS_OFS);
  assign tx_push  = done & pwrite & (paddr == spi_audio_pkg::TXDATA_OFS) &
                    (tx_cnt_q != FULL);
  assign rx_pop   = done & ~pwrite & (paddr == spi_audio_pkg::RXDATA_OFS) &
                    (rx_cnt_q != '0);
  assign off_now  = wr_ctrl & on & ~pwdata[spi_audio_pkg::ON_BIT];

  // register write values with their write locks
  always_comb
  begin
    ctrl_wval = pwdata & spi_audio_pkg::CTRL_WMASK;
    if (!ctrl_q[spi_audio_pkg::MASTER_MODE_SELECT_BIT])
      ctrl_wval[spi_audio_pkg::SMP_BIT] = 1'b0;
    ctrl2_wval = pwdata & spi_audio_pkg::CTRL2_WMASK;
    if (on)
      ctrl2_wval = (ctrl2_wval & ~spi_audio_pkg::CTRL2_AUDIO_MASK) |
                   (ctrl2_q & spi_audio_pkg::CTRL2_AUDIO_MASK);
  end

  // status word and read mux
  always_comb
  begin
    status = 32'h0000_0000;
    status[spi_audio_pkg::ST_RXNE_BIT]  = (rx_cnt_q != '0);
    status[spi_audio_pkg::ST_TXFUL_BIT] = (tx_cnt_q == FULL);
    status[spi_audio_pkg::ST_BUSY_BIT]  =
      (state_q == spi_audio_pkg::ST_RUN) | loaded_q;
    status[spi_audio_pkg::ST_HALT_BIT]  = (state_q == spi_audio_pkg::ST_HALT);
    status[spi_audio_pkg::ST_OVF_BIT]   = ovf_q;
    status[spi_audio_pkg::ST_URF_BIT]   = urf_q;
    status[spi_audio_pkg::ST_FEF_BIT]   = fef_q;
    status[spi_audio_pkg::ST_PROT_LSB +: 2] = prot_eff;
    status[spi_audio_pkg::ST_MONO_BIT]  = mono_eff;
    unique case (paddr)
      spi_audio_pkg::CTRL_OFS:   rd_data = ctrl_q;
      spi_audio_pkg::CTRL2_OFS:  rd_data = ctrl2_q;
      spi_audio_pkg::STATUS_OFS: rd_data = status;
      spi_audio_pkg::RXDATA_OFS:
        if (ctrl2_q[spi_audio_pkg::SGNEXT_BIT])
          rd_data = {{(32 - W){rx_mem[rx_rp_q][W-1]}}, rx_mem[rx_rp_q]};
        else
          rd_data = {{(32 - W){1'b0}}, rx_mem[rx_rp_q]};
      default:                   rd_data = 32'h0000_0000;
    endcase
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready)
        prdata <= rd_data;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      ctrl_q  <= spi_audio_pkg::CTRL_RESET;
      ctrl2_q <= spi_audio_pkg::CTRL2_RESET;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl_q <= ctrl_wval;
      if (wr_ctrl2)
        ctrl2_q <= ctrl2_wval;
    end
  end

  // two-flop synchronisers for the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      sclk_m_q    <= 1'b0;
      sclk_s_q    <= 1'b0;
      sclk_prev_q <= 1'b0;
      sdi_m_q     <= 1'b0;
      sdi_s_q     <= 1'b0;
      ss_m_q      <= 1'b1;
      ss_s_q      <= 1'b1;
    end else if (ce) begin
      sclk_m_q    <= sclk_in;
      sclk_s_q    <= sclk_m_q;
      sclk_prev_q <= sclk_s_q;
      sdi_m_q     <= sdi_in;
      sdi_s_q     <= sdi_m_q;
      ss_m_q      <= ss_n_in;
      ss_s_q      <= ss_m_q;
    end
  end

  // engine state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= spi_audio_pkg::ST_IDLE;
    else if (ce) begin
      if (!on)
        state_q <= spi_audio_pkg::ST_IDLE;
      else
        unique case (state_q)
          spi_audio_pkg::ST_IDLE:
            if (master ? start_m : sel)
              state_q <= crit ? spi_audio_pkg::ST_HALT
                              : spi_audio_pkg::ST_RUN;
          spi_audio_pkg::ST_RUN:
            if (crit)
              state_q <= spi_audio_pkg::ST_HALT;
            else if (master ? last : !sel)
              state_q <= spi_audio_pkg::ST_IDLE;
          spi_audio_pkg::ST_HALT:
            state_q <= spi_audio_pkg::ST_HALT;
          default:
            state_q <= spi_audio_pkg::ST_IDLE;
        endcase
    end
  end

  // half-period divider and bit position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      half_q <= '0;
      div_q  <= '0;
    end else if (ce) begin
      if (state_q != spi_audio_pkg::ST_RUN || (!master && !sel)) begin
        half_q <= '0;
        div_q  <= '0;
      end else if (master && div_q != DIV_LAST)
        div_q <= div_q + 1'b1;
      else if (tick) begin
        div_q  <= '0;
        half_q <= last ? '0 : half_q + 1'b1;
      end
    end
  end

  // master clock output, idle level from the effective polarity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_out <= 1'b0;
    else if (ce) begin
      if (state_q != spi_audio_pkg::ST_RUN)
        sclk_out <= cpol_eff;
      else if (master && tick && half_q != LAST_M)
        sclk_out <= ~sclk_out;
    end
  end

  // transmit shifter, mono repeat and channel tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      tx_sh_q     <= '0;
      loaded_q    <= 1'b0;
      last_word_q <= '0;
      chan_q      <= 1'b0;
    end else if (ce) begin
      if (!on) begin
        tx_sh_q  <= '0;
        loaded_q <= 1'b0;
        chan_q   <= 1'b0;
      end else begin
        if (load_now) begin
          tx_sh_q  <= repeat_word ? last_word_q : tx_mem[tx_rp_q];
          loaded_q <= 1'b1;
          if (!repeat_word)
            last_word_q <= tx_mem[tx_rp_q];
        end else if (starved)
          tx_sh_q <= '0;
        else if (shf)
          tx_sh_q <= {tx_sh_q[W-2:0], 1'b0};
        if (last) begin
          loaded_q <= 1'b0;
          chan_q   <= audio & ~chan_q;
        end
      end
    end
  end

  // receive shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_sh_q <= '0;
    else if (ce) begin
      if (!on)
        rx_sh_q <= '0;
      else if (cap)
        rx_sh_q <= rx_word;
    end
  end

  // buffer storage, no reset needed
  always_ff @(posedge pclk)
  begin
    if (ce && tx_push)
      tx_mem[tx_wp_q] <= pwdata[W-1:0];
    if (ce && rx_push)
      rx_mem[rx_wp_q] <= rx_word;
  end

  // buffer pointers and fill levels, flushed when the port is turned off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else if (ce) begin
      if (off_now) begin
        tx_wp_q  <= '0;
        tx_rp_q  <= '0;
        tx_cnt_q <= '0;
        rx_wp_q  <= '0;
        rx_rp_q  <= '0;
        rx_cnt_q <= '0;
      end else begin
        if (tx_push)
          tx_wp_q <= ptr_next(tx_wp_q);
        if (tx_pop)
          tx_rp_q <= ptr_next(tx_rp_q);
        if (tx_push != tx_pop)
          tx_cnt_q <= tx_push ? tx_cnt_q + 1'b1 : tx_cnt_q - 1'b1;
        if (rx_push)
          rx_wp_q <= ptr_next(rx_wp_q);
        if (rx_pop)
          rx_rp_q <= ptr_next(rx_rp_q);
        if (rx_push != rx_pop)
          rx_cnt_q <= rx_push ? rx_cnt_q + 1'b1 : rx_cnt_q - 1'b1;
      end
    end
  end

  // sticky error flags, a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      ovf_q       <= 1'b0;
      urf_q       <= 1'b0;
      fef_q       <= 1'b0;
      error_event <= 1'b0;
    end else if (ce) begin
      ovf_q <= (ovf_q & ~(wr_stat & pwdata[spi_audio_pkg::ST_OVF_BIT])) |
               over;
      urf_q <= (urf_q & ~(wr_stat & pwdata[spi_audio_pkg::ST_URF_BIT])) |
               starved;
      fef_q <= (fef_q & ~(wr_stat & pwdata[spi_audio_pkg::ST_FEF_BIT])) |
               frame_err;
      error_event <=
        (over & ctrl2_q[spi_audio_pkg::OVEN_BIT]) |
        (starved & ctrl2_q[spi_audio_pkg::UREN_BIT]) |
        (frame_err & ctrl2_q[spi_audio_pkg::FEEN_BIT]);
    end
  end

  // buffer interrupts and pin ownership
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) begin
      tx_irq   <= 1'b0;
      rx_irq   <= 1'b0;
      sclk_oe  <= 1'b0;
      sdo_oe   <= 1'b0;
      sdi_used <= 1'b0;
      ss_used  <= 1'b0;
    end else if (ce) begin
      unique case (ctrl_q[spi_audio_pkg::TXMODE_LSB +: 2])
        spi_audio_pkg::IRQ_SPACE: tx_irq <= on && (tx_cnt_q != FULL);
        spi_audio_pkg::IRQ_HALF:  tx_irq <= on && (tx_cnt_q <= TX_HALF);
        spi_audio_pkg::IRQ_EDGE:  tx_irq <= on && (tx_cnt_q == '0);
        spi_audio_pkg::IRQ_DONE:
          tx_irq <= on && (tx_cnt_q == '0) && !loaded_q &&
                    (state_q != spi_audio_pkg::ST_RUN);
      endcase
      unique case (ctrl_q[spi_audio_pkg::RXMODE_LSB +: 2])
        spi_audio_pkg::IRQ_SPACE: rx_irq <= on && rx_full;
        spi_audio_pkg::IRQ_HALF:  rx_irq <= on && (rx_cnt_q >= RX_HALF);
        spi_audio_pkg::IRQ_EDGE:  rx_irq <= on && (rx_cnt_q != '0);
        spi_audio_pkg::IRQ_DONE:  rx_irq <= rx_pop && (rx_cnt_q == ONE);
      endcase
      sclk_oe  <= on & master;
      sdo_oe   <= on & (master | sel);
      sdi_used <= on & ~ctrl_q[spi_audio_pkg::SERIAL_INPUT_DISABLE_BIT];
      ss_used  <= on & ~master & ctrl_q[spi_audio_pkg::SLAVE_SELECT_ENABLE_BIT];
    end
  end

  assign sdo_out = tx_sh_q[W-1];

endmodule // spi_audio_serial_port

//--- include/spi_audio_pkg.sv
// package: register map, field positions, reset values and codes
package spi_audio_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CTRL2_OFS  = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // reset values and writable masks
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] CTRL2_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK       = 32'h0000_83FF;
  localparam logic [31:0] CTRL2_WMASK      = 32'h0000_9F8B;
  localparam logic [31:0] CTRL2_AUDIO_MASK = 32'h0000_008B;
  localparam logic [31:0] STATUS_W1C_MASK  = 32'h0000_0070;

  // serial_port_control fields
  localparam int ON_BIT     = 15;
  localparam int SMP_BIT    = 9;
  localparam int CKE_BIT    = 8;
  localparam int SLAVE_SELECT_ENABLE_BIT   = 7;
  localparam int CKP_BIT    = 6;
  localparam int MASTER_MODE_SELECT_BIT  = 5;
  localparam int SERIAL_INPUT_DISABLE_BIT = 4;
  localparam int TXMODE_LSB = 2;
  localparam int RXMODE_LSB = 0;

  // serial_port_control_two fields
  localparam int SGNEXT_BIT = 15;
  localparam int FEEN_BIT   = 12;
  localparam int OVEN_BIT   = 11;
  localparam int UREN_BIT   = 10;
  localparam int IGNOV_BIT  = 9;
  localparam int IGNUR_BIT  = 8;
  localparam int AUDIO_ENABLE_BIT  = 7;
  localparam int MONO_BIT   = 3;
  localparam int AUDIO_PROTOCOL_SELECT_LSB = 0;

  // status fields
  localparam int ST_RXNE_BIT  = 0;
  localparam int ST_TXFUL_BIT = 1;
  localparam int ST_BUSY_BIT  = 2;
  localparam int ST_HALT_BIT  = 3;
  localparam int ST_OVF_BIT   = 4;
  localparam int ST_URF_BIT   = 5;
  localparam int ST_FEF_BIT   = 6;
  localparam int ST_PROT_LSB  = 8;
  localparam int ST_MONO_BIT  = 10;

  // buffer interrupt mode codes
  localparam logic [1:0] IRQ_SPACE = 2'h3;
  localparam logic [1:0] IRQ_HALF  = 2'h2;
  localparam logic [1:0] IRQ_EDGE  = 2'h1;
  localparam logic [1:0] IRQ_DONE  = 2'h0;

  // audio protocol codes
  localparam logic [1:0] PROTO_PCM = 2'h3;
  localparam logic [1:0] PROTO_RJ  = 2'h2;
  localparam logic [1:0] PROTO_LJ  = 2'h1;
  localparam logic [1:0] PROTO_I2S = 2'h0;

  // default sizes and counts
  localparam int DATA_W_DEF     = 8;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int HALF_DIV_DEF   = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_HALT = 3'h4
  } eng_state_t;

endpackage

//--- verification/spi_audio_sva.sv
// checker: bus and pin relations of the serial port
`timescale 1ns/1ns

module spi_audio_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        sdo_oe,
  input wire logic        ss_used,
  input wire logic        error_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // five aligned words from offset zero are decoded
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h10);
  // setup cycle followed by the first access cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  AST_WAIT_STATE: assert property (s_setup ##1 s_access |-> ##1 pready)
    else $error("answer not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_DECODE: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match decode");
  AST_READ_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  AST_MASTER_DRIVES: assert property (sclk_oe |-> sdo_oe)
    else $error("master not driving data out");
  AST_SLAVE_SELECT: assert property (ss_used |-> !sclk_oe)
    else $error("select pin used while master");
  AST_EVENT_PULSE: assert property (error_event |=> !error_event)
    else $error("error event longer than one cycle");
  AST_HALF_PERIOD: assert property (sclk_oe && $changed(sclk_out) |=>
    $stable(sclk_out)[*3])
    else $error("serial clock half period too short");
endmodule // spi_audio_sva

bind spi_audio_serial_port spi_audio_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo_oe(sdo_oe),
  .ss_used(ss_used), .error_event(error_event));

//--- verification/spi_slave_model.sv
// partner: serial slave answering the port's master clock
`timescale 1ns/1ns

module spi_slave_model #(
  parameter logic [7:0] REPLY = 8'h96
) (
  input  wire logic sclk,
  input  wire logic sel,
  output logic      sdi
);
  logic [7:0] sh = REPLY;
  // rotate on each trailing edge so a bit is steady at the leading edge
  always @(negedge sclk)
    if (sel)
      sh <= {sh[6:0], sh[7]};
  // released line shows the inverse of the top bit, the next one to send
  assign sdi = sel ? sh[7] : ~sh[7];
endmodule // spi_slave_model

//--- verification/tb.sv
// testbench: register, pin and link scenarios for the serial port
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end

module tb;
  localparam logic [7:0] C1 = spi_audio_pkg::CTRL_OFS;
  localparam logic [7:0] C2 = spi_audio_pkg::CTRL2_OFS;
  localparam logic [7:0] TX = spi_audio_pkg::TXDATA_OFS;
  localparam logic [7:0] RX = spi_audio_pkg::RXDATA_OFS;
  localparam logic [7:0] ST = spi_audio_pkg::STATUS_OFS;
  logic        pclk, presetn, psel, penable, pwrite, sclk_in, sdi_in, er;
  logic [7:0]  paddr, cap;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sclk_out, sclk_oe, sdo_out, sdo_oe;
  logic        sdi_used, ss_used, tx_irq, rx_irq, error_event, ev_seen;
  int          n_errors = 0;
  int          total_checks = 0;

  spi_audio_serial_port dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(sclk_in), .sdi_in(sdi_in), .ss_n_in(1'b1),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .sdi_used(sdi_used), .ss_used(ss_used),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .error_event(error_event));
  spi_slave_model partner (.sclk(sclk_out), .sel(sclk_oe), .sdi(sdi_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // sent bits taken at the leading edge; error pulses remembered
  always @(posedge sclk_out)
    if (sclk_oe)
      cap <= {cap[6:0], sdo_out};
  always @(posedge pclk)
    if (error_event)
      ev_seen <= 1'b1;

  // one bus transfer: setup, access held until ready
  // the idle edge after each transfer keeps the off-write apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20 && pready !== 1'b1; t++)
      @(posedge pclk);
    if (t == 20)
      n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_regs;
    apb(1'b0, C1, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, C2, 32'h0);
    `CHK("ctrl2", 32'h0, rd)
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    `CHK("slverr", 1'b1, er)
  endtask

  task t_smp;
    apb(1'b1, C1, 32'h200);
    apb(1'b0, C1, 32'h0);
    `CHK("smp_slave", 32'h0, rd)
    apb(1'b1, C1, 32'h20); // master first
    apb(1'b1, C1, 32'h220);
    apb(1'b0, C1, 32'h0);
    `CHK("smp_master", 32'h220, rd)
    `CHK("oe_off", 1'b0, sclk_oe)
    apb(1'b1, C1, 32'h0);
  endtask

  task t_audio;
    apb(1'b1, C1, 32'h40);
    repeat (2) @(posedge pclk);
    `CHK("idle_high", 1'b1, sclk_out)
    apb(1'b1, C1, 32'h0);
    apb(1'b1, C2, 32'h0A);
    apb(1'b0, ST, 32'h0);
    `CHK("eff_off", 3'h0, rd[10:8])
    apb(1'b1, C2, 32'h8A);
    apb(1'b0, ST, 32'h0);
    `CHK("eff_on", 3'h6, rd[10:8])
    `CHK("audio_pol", 1'b1, sclk_out)
    apb(1'b1, C1, 32'h8000);
    apb(1'b1, C2, 32'h0);
    apb(1'b0, C2, 32'h0);
    `CHK("audio_lock", 32'h8A, rd)
    apb(1'b1, C1, 32'h0);
    apb(1'b1, C2, 32'h0);
  endtask

  task t_master;
    int i;
    apb(1'b1, C2, 32'h8000);
    apb(1'b1, C1, 32'h8120);
    repeat (2) @(posedge pclk);
    `CHK("sdi_used", 1'b1, sdi_used)
    `CHK("master_oe", 1'b1, sclk_oe)
    apb(1'b1, TX, 32'hA5);
    for (i = 0; i < 40; i++)
    begin
      apb(1'b0, ST, 32'h0);
      if (rd[0] === 1'b1)
        break;
    end
    `CHK("sent", 8'hA5, cap)
    apb(1'b0, RX, 32'h0);
    `CHK("rx_sext", 32'hFFFF_FF96, rd)
    @(posedge pclk);
    `CHK("rx_irq_read", 1'b1, rx_irq)
    `CHK("tx_irq_done", 1'b1, tx_irq)
    apb(1'b1, C1, 32'h8090);
    repeat (2) @(posedge pclk);
    `CHK("ss_used", 1'b1, ss_used)
    `CHK("sdi_free", 1'b0, sdi_used)
    apb(1'b1, C1, 32'h0);
  endtask

  task t_underrun;
    apb(1'b1, C2, 32'h400);
    apb(1'b1, C1, 32'h8000);
    repeat (4)
    begin
      #62 sclk_in <= 1'b1;
      #63 sclk_in <= 1'b0;
    end
    repeat (10) @(posedge pclk);
    `CHK("event", 1'b1, ev_seen)
    apb(1'b0, ST, 32'h0);
    `CHK("halted", 2'h3, {rd[3], rd[5]})
    apb(1'b1, C1, 32'h0);
  endtask

  task summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, sclk_in, ev_seen} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_smp();
    t_audio();
    t_master();
    t_underrun();
    summarize();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #300000;
    n_errors++;
    summarize();
  end
endmodule // tb
